// File: design/smwc_pkg.sv
/*
  Package for the sleep and wake controller: mode codes, state encodings
  and timing counts. Assumes a 20 MHz system clock.
*/
package smwc_pkg;
  localparam logic [2:0] MODE_NORMAL = 3'h0;
  localparam logic [2:0] MODE_SLEEP = 3'h6;
  localparam int CLK_HZ = 20000000;
  // Power-up sequence length in ns, converted to whole cycles (round up)
  localparam int PWRUP_NS = 2000;
  localparam int PWRUP_CYC = (PWRUP_NS * (CLK_HZ / 1000000) + 999) / 1000;
  localparam logic [7:0] PWRUP_LAST = 8'(PWRUP_CYC - 1);
  localparam logic [3:0] WAKE_HIGH_MIN = 4'h4;
  localparam logic [1:0] CONV_AFTER_WAKE = 2'h2;
  typedef enum logic [2:0]
  {
    ST_RUN = 3'b000,
    ST_SLEEP = 3'b001,
    ST_PWRUP = 3'b010,
    ST_CONV1 = 3'b011,
    ST_CONV2 = 3'b100
  } smwc_state_e;
endpackage

// File: design/smwc_top.sv
/*
  Sleep entry, wake and mode resumption controller for a converter's
  digital section. Assumes the serial port decodes mode writes and
  reports conversion cycle boundaries on the system clock; the crystal
  clock drives wake detection.
*/
`timescale 1ns/100ps
module smwc_top
  import smwc_pkg::*;
(
  input wire logic CLK_SYS,
  input wire logic NRST,
  input wire logic CRYSTAL_CLOCK_INPUT,
  input wire logic CHIP_SELECT_N,
  input wire logic SERIAL_DATA_LINE,
  input wire logic MASTER_MODE,
  input wire logic INSTRUCTION_BYTE_SEEN,
  input wire logic MODE_WRITE,
  input wire logic [2:0] MODE_WDATA,
  input wire logic CAL_DONE,
  input wire logic CONV_END,
  input wire logic RESULT_VALID,
  output logic [2:0] OPERATING_MODE_FIELD,
  output logic ANALOG_POWER_EN,
  output logic DIGITAL_POWER_EN,
  output logic SERIAL_PORT_EN,
  output logic DATA_READY_N,
  output logic ASLEEP
);
  logic [1:0] rst_sync;
  logic rst_n;
  logic [1:0] xrst_sync;
  logic xrst_n;
  smwc_state_e state;
  smwc_state_e next_state;
  logic [2:0] mode;
  logic [2:0] pend_mode;
  logic [7:0] pwr_cnt;
  logic port_on;
  smwc_wake_if wif ();
  assign rst_n = rst_sync[1];
  assign xrst_n = xrst_sync[1];

  // Reset release through two flops in each domain
  always_ff @(posedge CLK_SYS or negedge NRST)
  begin
    if (!NRST)
      rst_sync <= 2'h0;
    else
      rst_sync <= {rst_sync[0], 1'b1};
  end

  // Crystal domain gets its own released copy
  always_ff @(posedge CRYSTAL_CLOCK_INPUT or negedge NRST)
  begin
    if (!NRST)
      xrst_sync <= 2'h0;
    else
      xrst_sync <= {xrst_sync[0], 1'b1};
  end

  smwc_wake_det u_det
  (
    .xclk(CRYSTAL_CLOCK_INPUT),
    .xrst_n(xrst_n),
    .clk(CLK_SYS),
    .rst_n(rst_n),
    .cs_n(CHIP_SELECT_N),
    .sdata(SERIAL_DATA_LINE),
    .master(MASTER_MODE),
    .instr_seen(INSTRUCTION_BYTE_SEEN),
    .wif(wif.det)
  );

  // Decode of mode writes; writes are ignored while the port sleeps
  wire wr_ok = MODE_WRITE & (state != ST_SLEEP | port_on);
  wire wr_sleep = wr_ok & (MODE_WDATA == MODE_SLEEP);
  wire wr_wake = wr_ok & (state == ST_SLEEP) &
    (MODE_WDATA != MODE_SLEEP);
  wire pwr_done = (pwr_cnt == PWRUP_LAST);
  assign wif.armed = (state == ST_SLEEP) & ~port_on;

  // Next-state selection
  always_comb
  begin
    next_state = state;
    case (state)
      ST_RUN:
        if (wr_sleep)
          next_state = ST_SLEEP;
      ST_SLEEP:
        if (wr_wake)
          next_state = ST_PWRUP;
      ST_PWRUP:
        if (pwr_done)
          next_state = ST_CONV1;
      ST_CONV1:
        if (CONV_END)
          next_state = ST_CONV2;
      ST_CONV2:
        if (CONV_END)
          next_state = ST_RUN;
      default:
        next_state = ST_RUN;
    endcase
  end

  // State, power-up counter and serial port wake latch
  always_ff @(posedge CLK_SYS or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state <= ST_RUN;
      pwr_cnt <= 8'h0;
      port_on <= 1'b0;
    end
    else
    begin
      state <= next_state;
      pwr_cnt <= (state == ST_PWRUP) ? pwr_cnt + 8'h1 : 8'h0;
      if (state != ST_SLEEP)
        port_on <= 1'b0;
      else if (wif.wake)
        port_on <= 1'b1;
    end
  end

  // Mode field: new mode held pending until first conversion ends
  always_ff @(posedge CLK_SYS or negedge rst_n)
  begin
    if (!rst_n)
    begin
      mode <= MODE_NORMAL;
      pend_mode <= MODE_NORMAL;
    end
    else if (wr_wake)
      pend_mode <= MODE_WDATA;
    else if (state == ST_CONV1 && CONV_END)
      mode <= pend_mode;
    else if (wr_ok && state != ST_SLEEP)
      mode <= MODE_WDATA;
    else if (wr_sleep)
      mode <= MODE_SLEEP;
    else if (CAL_DONE)
      mode <= MODE_NORMAL;
  end

  // Registered outputs; bias and reference stay with the host
  always_ff @(posedge CLK_SYS or negedge rst_n)
  begin
    if (!rst_n)
    begin
      OPERATING_MODE_FIELD <= MODE_NORMAL;
      ANALOG_POWER_EN <= 1'b1;
      DIGITAL_POWER_EN <= 1'b1;
      SERIAL_PORT_EN <= 1'b1;
      DATA_READY_N <= 1'b1;
      ASLEEP <= 1'b0;
    end
    else
    begin
      OPERATING_MODE_FIELD <= (state == ST_SLEEP) ? MODE_SLEEP :
        (state == ST_RUN ? mode : pend_mode);
      ANALOG_POWER_EN <= (next_state != ST_SLEEP);
      DIGITAL_POWER_EN <= (next_state != ST_SLEEP);
      SERIAL_PORT_EN <= (next_state != ST_SLEEP) | port_on | wif.wake;
      // Low only in normal running with a valid result
      DATA_READY_N <= ~((next_state == ST_RUN) & (state == ST_RUN) &
        RESULT_VALID);
      ASLEEP <= (next_state == ST_SLEEP);
    end
  end
endmodule

// File: design/smwc_wake_det.sv
/*
  Crystal-clocked wake detector for sleep. Watches chip select and the
  serial data line, and the slave instruction strobe. A wake event is
  chip select or data line wake is passed to the system domain by a toggle. Assumes the crystal clock runs.
*/
`timescale 1ns/100ps
module smwc_wake_det
  import smwc_pkg::*;
(
  input wire logic xclk,
  input wire logic xrst_n,
  input wire logic clk,
  input wire logic rst_n,
  input wire logic cs_n,
  input wire logic sdata,
  input wire logic master,
  input wire logic instr_seen,
  smwc_wake_if.det wif
);
  logic [2:0] cs_s;
  logic [2:0] sd_s;
  logic [2:0] ar_s;
  logic [2:0] ms_s;
  logic [3:0] high_cnt;
  logic tog;
  logic [2:0] tog_s;
  logic [2:0] in_s;
  wire cs_lo = ~cs_s[1] & ~cs_s[2];
  wire sd_hi = sd_s[1] & sd_s[2];
  wire sd_fall = ~sd_s[1] & sd_s[2];
  wire armed_x = ar_s[1] & ar_s[2];
  // Master select comes from the system clock, so it is resynchronised
  wire master_x = ms_s[1] & ms_s[2];
  // Pin high for N periods gives N-1 agreeing samples, hence minimum - 1
  wire edge_ok = sd_fall & (high_cnt >= WAKE_HIGH_MIN - 4'h1);
  wire cs_wake = cs_s[2] & ~cs_s[1];
  wire x_wake = armed_x & (cs_wake | (cs_lo & master_x & edge_ok));
  // Crystal-domain synchronisers and high-time counter
  always_ff @(posedge xclk or negedge xrst_n)
  begin
    if (!xrst_n)
    begin
      cs_s <= 3'h7;
      sd_s <= 3'h7;
      ar_s <= 3'h0;
      ms_s <= 3'h0;
      high_cnt <= 4'h0;
      tog <= 1'b0;
    end
    else
    begin
      cs_s <= {cs_s[1:0], cs_n};
      sd_s <= {sd_s[1:0], sdata};
      ar_s <= {ar_s[1:0], wif.armed};
      ms_s <= {ms_s[1:0], master};
      high_cnt <= !sd_hi ? 4'h0 :
        (high_cnt == 4'hF ? high_cnt : high_cnt + 4'h1);
      tog <= tog ^ x_wake;
    end
  end
  // Toggle returns to system domain; slave instruction is same-domain
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      tog_s <= 3'h0;
      in_s <= 3'h0;
    end
    else
    begin
      tog_s <= {tog_s[1:0], tog};
      in_s <= {in_s[1:0], instr_seen};
    end
  end
  // Slave mode, chip select not checked: plain instruction byte wakes the port
  assign wif.wake = (tog_s[2] ^ tog_s[1]) |
    (~master & in_s[1] & ~in_s[2]);
endmodule

// File: design/smwc_wake_if.sv
/*
  Interface carrying wake detector results to the controller.
  Assumes both ends sit in the system clock domain.
*/
`timescale 1ns/100ps
interface smwc_wake_if;
  logic armed;
  logic wake;
  modport det
  (
    input armed,
    output wake
  );
  modport ctl
  (
    output armed,
    input wake
  );
endinterface

// File: tb/smwc_asserts.sv
/* Port checker for the sleep controller.
   Assumes binding onto smwc_top. */
`timescale 1ns/100ps
module smwc_asserts
  import smwc_pkg::*;
(
  input wire logic CLK_SYS,
  input wire logic NRST,
  input wire logic MODE_WRITE,
  input wire logic [2:0] MODE_WDATA,
  input wire logic RESULT_VALID,
  input wire logic ANALOG_POWER_EN,
  input wire logic DIGITAL_POWER_EN,
  input wire logic SERIAL_PORT_EN,
  input wire logic DATA_READY_N,
  input wire logic ASLEEP
);
  default clocking cb @(posedge CLK_SYS);
  endclocking
  default disable iff (!NRST);
  // Entry and holding of sleep
  sleep_entry_a: assert property (MODE_WRITE && MODE_WDATA == MODE_SLEEP
    && !ASLEEP |-> ##[1:2] ASLEEP) else $error("sleep not entered");
  stay_asleep_a: assert property (ASLEEP && !MODE_WRITE
    && !$past(MODE_WRITE) |=> ASLEEP) else $error("sleep left early");
  sleep_power_a: assert property (ASLEEP |->
    !ANALOG_POWER_EN && !DIGITAL_POWER_EN) else $error("powered in sleep");
  port_off_a: assert property ($rose(ASLEEP) |->
    !SERIAL_PORT_EN) else $error("port on at sleep");
  // Data ready stays high around wake; low only on a valid result
  sleep_data_ready_n_a: assert property (ASLEEP |-> DATA_READY_N)
    else $error("ready low in sleep");
  wake_data_ready_n_a: assert property ($fell(ASLEEP) |-> DATA_READY_N [*8])
    else $error("ready low after wake");
  wake_power_a: assert property ($fell(ASLEEP) |-> ##[0:2]
    ANALOG_POWER_EN && DIGITAL_POWER_EN) else $error("no power-up");
  data_ready_n_valid_a: assert property (!DATA_READY_N |-> $past(RESULT_VALID))
    else $error("ready without result");
  cover property ($rose(ASLEEP));
  cover property ($fell(ASLEEP));
  cover property ($fell(DATA_READY_N));
endmodule
bind smwc_top smwc_asserts i_smwc_asserts (.CLK_SYS, .NRST, .MODE_WRITE,
  .MODE_WDATA, .RESULT_VALID, .ANALOG_POWER_EN, .DIGITAL_POWER_EN,
  .SERIAL_PORT_EN, .DATA_READY_N, .ASLEEP);

// File: tb/smwc_host_model.sv
/* Host model driving the data line for a master-mode wake.
   Assumes go rises only while the converter sleeps. */
`timescale 1ns/100ps
module smwc_host_model
(
  input wire logic xclk,
  input wire logic go,
  output logic sdata
);
  logic [2:0] cnt = 3'h0;
  initial sdata = 1'h0;
  // Line idles low, so a high phase of exactly the minimum four periods
  // comes first; this keeps the detector's threshold at its boundary
  always @(posedge xclk)
  begin
    if (go && cnt != 3'h4)
    begin
      sdata <= 1'h1;
      cnt <= cnt + 3'h1;
    end
    else
    begin
      sdata <= 1'h0;
      if (!go)
        cnt <= 3'h0;
    end
  end
endmodule

// File: tb/smwc_tb_top.sv
/* Bench for the sleep controller.
   Assumes the package timing counts. */
`timescale 1ns/100ps
module smwc_tb_top
  import smwc_pkg::*;
;
  logic CLK_SYS = 0, NRST = 0, CRYSTAL_CLOCK_INPUT = 0, CHIP_SELECT_N = 1;
  logic MASTER_MODE = 0, INSTRUCTION_BYTE_SEEN = 0, MODE_WRITE = 0;
  logic CAL_DONE = 0, CONV_END = 0, RESULT_VALID = 1, go = 0;
  logic [2:0] MODE_WDATA = 3'h0;
  logic [2:0] OPERATING_MODE_FIELD;
  logic SERIAL_DATA_LINE, ANALOG_POWER_EN, DIGITAL_POWER_EN;
  logic SERIAL_PORT_EN, DATA_READY_N, ASLEEP;
  int n_mismatch = 0;
  int num_checks = 0;
  typedef struct {logic [2:0] wd; logic [2:0] fld;} smwc_row_s;
  smwc_row_s rows[7] = '{'{3'h1, 3'h1}, '{3'h2, 3'h2}, '{3'h3, 3'h3},
    '{3'h4, 3'h4}, '{3'h5, 3'h5}, '{3'h7, 3'h7}, '{3'h0, 3'h0}};
  smwc_top i_smwc_top (.CLK_SYS, .NRST, .CRYSTAL_CLOCK_INPUT, .CHIP_SELECT_N,
    .SERIAL_DATA_LINE, .MASTER_MODE, .INSTRUCTION_BYTE_SEEN, .MODE_WRITE,
    .MODE_WDATA, .CAL_DONE, .CONV_END, .RESULT_VALID, .OPERATING_MODE_FIELD,
    .ANALOG_POWER_EN, .DIGITAL_POWER_EN, .SERIAL_PORT_EN, .DATA_READY_N,
    .ASLEEP);
  smwc_host_model i_smwc_host_model (.xclk(CRYSTAL_CLOCK_INPUT), .go,
    .sdata(SERIAL_DATA_LINE));
  // Two unrelated clocks
  initial forever #25 CLK_SYS = ~CLK_SYS;
  initial
  begin
    #7;
    forever #24 CRYSTAL_CLOCK_INPUT = ~CRYSTAL_CLOCK_INPUT;
  end
  task cyc(input int n);
    repeat (n) @(posedge CLK_SYS);
    #2;
  endtask
  task chk(input logic [2:0] seen, input logic [2:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("wrong value at %0t: %h expected %h", $time, seen, exp);
    end
  endtask
  task conclude;
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  task wr(input logic [2:0] v);
    MODE_WDATA = v;
    MODE_WRITE = 1;
    cyc(1);
    MODE_WRITE = 0;
    cyc(2);
  endtask
  // Sleep, a refused early write, wake by method m, then resume
  task sleep_cycle(input int m);
    int i;
    // Bias and reference enables sit outside this block, so the host's
    // sleep and wake writes carry no change to them
    wr(MODE_SLEEP);
    chk(ASLEEP, 1);
    chk(ANALOG_POWER_EN | DIGITAL_POWER_EN, 0);
    wr(MODE_NORMAL);
    chk(ASLEEP, 1);
    CHIP_SELECT_N = 0;
    go = (m == 1);
    INSTRUCTION_BYTE_SEEN = (m == 2);
    for (i = 0; i < 200 && SERIAL_PORT_EN !== 1'b1; i++)
      cyc(1);
    chk(SERIAL_PORT_EN, 1);
    if (i == 200)
      conclude();
    go = 0;
    INSTRUCTION_BYTE_SEEN = 0;
    wr(MODE_NORMAL);
    chk(ASLEEP, 0);
    chk(ANALOG_POWER_EN & DIGITAL_POWER_EN, 1);
    cyc(PWRUP_CYC);
    repeat (2)
    begin
      chk(DATA_READY_N, 1);
      CONV_END = 1;
      cyc(1);
      CONV_END = 0;
      cyc(3);
    end
    chk(DATA_READY_N, 0);
    RESULT_VALID = 0;
    cyc(3);
    chk(DATA_READY_N, 1);
    RESULT_VALID = 1;
    $display("wake test %0d done", m);
  endtask
  initial
  begin
    cyc(2);
    chk({ANALOG_POWER_EN, SERIAL_PORT_EN, DATA_READY_N}, 3'h7);
    NRST = 1;
    cyc(4);
    foreach (rows[i])
    begin
      wr(rows[i].wd);
      chk(OPERATING_MODE_FIELD, rows[i].fld);
    end
    wr(3'h1);
    CAL_DONE = 1;
    cyc(1);
    CAL_DONE = 0;
    cyc(2);
    chk(OPERATING_MODE_FIELD, MODE_NORMAL);
    $display("mode tests done");
    for (int m = 0; m < 3; m++)
    begin
      MASTER_MODE = (m == 1);
      sleep_cycle(m);
    end
    // Reset in mid-run while asleep returns to the running defaults
    wr(MODE_SLEEP);
    chk(ASLEEP, 1);
    NRST = 0;
    cyc(2);
    chk({ASLEEP, ANALOG_POWER_EN, DATA_READY_N}, 3'h3);
    NRST = 1;
    cyc(4);
    chk(OPERATING_MODE_FIELD, MODE_NORMAL);
    wr(3'h5);
    chk(OPERATING_MODE_FIELD, 3'h5);
    $display("reset test done");
    conclude();
  end
endmodule
